/* include/bus_bridge_pkg.sv */
// Constants and types shared by the memory bus arbiter and peripheral bridge
`default_nettype none
package bus_bridge_pkg;
   localparam int PROG_AW = 22;
   localparam int DATA_AW = 32;
   localparam int DW = 32;
   localparam int PERIPH_AW = 16;
   localparam int HALF_W = 16;
   // Frame select, decoded from address bits above the peripheral offset
   localparam int FRAME_LSB = 16;
   localparam int FRAME_W = 2;
   localparam logic [1:0] FRAME_WIDE = 2'h1;
   localparam logic [1:0] FRAME_NARROW = 2'h2;
   localparam logic PROTECT_RESET = 1'b1;
   // Requesters, highest priority first
   typedef enum logic [2:0] {
      SRC_NONE, SRC_DWRITE, SRC_PWRITE, SRC_DREAD, SRC_PREAD, SRC_FETCH
   } source_t;
   typedef enum {
      ST_IDLE, ST_LOW, ST_HIGH
   } phase_t;
endpackage
`default_nettype wire

/* logic/priority_pick.sv */
// Fixed-priority one-of-five request picker
`timescale 1ns/1ps
`default_nettype none
module priority_pick (
   input wire logic [4:0] req,
   output bus_bridge_pkg::source_t pick
);
   import bus_bridge_pkg::*;
   // Bit 0 is data write (highest), bit 4 is fetch (lowest)
   always_comb begin
      if (req[0]) begin
         pick = SRC_DWRITE;
      end else if (req[1]) begin
         pick = SRC_PWRITE;
      end else if (req[2]) begin
         pick = SRC_DREAD;
      end else if (req[3]) begin
         pick = SRC_PREAD;
      end else if (req[4]) begin
         pick = SRC_FETCH;
      end else begin
         pick = SRC_NONE;
      end
   end
endmodule
`default_nettype wire

/* logic/memory_bus_priority_bridge.sv */
// Memory bus arbiter and peripheral bridge with two peripheral frames
//
// What this block does
// - Program read bus: 22-bit address, 32-bit data.
// - Data read and write buses: separate 32-bit address and data each.
// - A full 32-bit access to the wide frame finishes in one clock cycle; the narrow frame splits it into two halves over three.
// - Fetch, data read and data write are serialised: only one transfer issues per cycle.
// - Same-cycle requests to one target resolve by priority, not arrival.
// - Priority: data write, program write, data read, program read, fetch.
// - Bridge multiplexes buses onto a 16-bit address, 16/32-bit data bus.
// - Narrow frame accepts only 16-bit accesses.
// - Wide frame accepts both 16-bit and 32-bit accesses.
// - Protected accesses complete in program order, write before read.
// - Protection on by default, costs alignment cycles, software may disable.
`timescale 1ns/1ps
`default_nettype none
module memory_bus_priority_bridge (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic protect_en,
   // Program bus: fetch, program read, program write
   input wire logic fetch_req,
   input wire logic pread_req,
   input wire logic pwrite_req,
   input wire logic [bus_bridge_pkg::PROG_AW-1:0] prog_addr,
   input wire logic [bus_bridge_pkg::DW-1:0] prog_wdata,
   input wire logic prog_wide,
   // Data read bus
   input wire logic dread_req,
   input wire logic [bus_bridge_pkg::DATA_AW-1:0] dread_addr,
   input wire logic dread_wide,
   // Data write bus
   input wire logic dwrite_req,
   input wire logic [bus_bridge_pkg::DATA_AW-1:0] dwrite_addr,
   input wire logic [bus_bridge_pkg::DW-1:0] dwrite_data,
   input wire logic dwrite_wide,
   // Grants and read return
   output logic fetch_done,
   output logic pread_done,
   output logic pwrite_done,
   output logic dread_done,
   output logic dwrite_done,
   output logic [bus_bridge_pkg::DW-1:0] rdata,
   // Peripheral bus
   input wire logic [bus_bridge_pkg::DW-1:0] periph_rdata,
   output logic periph_sel_wide,
   output logic periph_sel_narrow,
   output logic periph_write,
   output logic periph_wide,
   output logic [bus_bridge_pkg::PERIPH_AW-1:0] periph_addr,
   output logic [bus_bridge_pkg::DW-1:0] periph_wdata,
   output logic protect_on
);
   import bus_bridge_pkg::*;

   // ==========================================
   // Request selection
   // ==========================================
   logic [4:0] pending;
   source_t winner;
   source_t last_src;
   logic order_hold;
   phase_t phase;
   logic [DW-1:0] hold_data;
   logic [DATA_AW-1:0] hold_addr;
   logic hold_write;
   logic [DATA_AW-1:0] win_addr;
   logic [DW-1:0] win_wdata;
   logic win_wide;
   logic win_write;
   logic [FRAME_W-1:0] win_frame;

   function automatic logic [FRAME_W-1:0] frame_of(input logic [DATA_AW-1:0] a);
      frame_of = a[FRAME_LSB +: FRAME_W];
   endfunction

   // Live requests: core keeps them asserted until done
   assign pending = {fetch_req, pread_req, dread_req, pwrite_req, dwrite_req};

   priority_pick u_pick (
      .req(pending),
      .pick(winner)
   );

   // Exclusive pairs share the program address bus safely
   always_comb begin
      win_addr = '0;
      win_wdata = '0;
      win_wide = 1'b0;
      win_write = 1'b0;
      case (winner)
         SRC_DWRITE: begin
            win_addr = dwrite_addr;
            win_wdata = dwrite_data;
            win_wide = dwrite_wide;
            win_write = 1'b1;
         end
         SRC_PWRITE: begin
            win_addr = {{(DATA_AW-PROG_AW){1'b0}}, prog_addr};
            win_wdata = prog_wdata;
            win_wide = prog_wide;
            win_write = 1'b1;
         end
         SRC_DREAD: begin
            win_addr = dread_addr;
            win_wide = dread_wide;
         end
         SRC_PREAD, SRC_FETCH: begin
            win_addr = {{(DATA_AW-PROG_AW){1'b0}}, prog_addr};
            win_wide = prog_wide;
         end
         default: begin
            win_addr = '0;
         end
      endcase
   end
   assign win_frame = frame_of(win_addr);

   // Read right after a data write in protected frame waits one alignment cycle
   logic protected_read;
   assign protected_read = protect_on && !win_write && last_src == SRC_DWRITE
                           && !order_hold && winner != SRC_NONE
                           && (win_frame == FRAME_WIDE || win_frame == FRAME_NARROW);

   // ==========================================
   // Protection mode
   // ==========================================
   // Enabled after reset, then follows software control
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         protect_on <= PROTECT_RESET;
      end else begin
         protect_on <= protect_en;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         order_hold <= 1'b0;
      end else begin
         order_hold <= protected_read;
      end
   end

   // ==========================================
   // Transfer sequencer
   // ==========================================
   logic split;
   // Narrow frame wide access splits in two halves
   assign split = win_wide && win_frame == FRAME_NARROW;

   logic issue;
   assign issue = phase == ST_IDLE && winner != SRC_NONE && !protected_read;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         phase <= ST_IDLE;
         last_src <= SRC_NONE;
         hold_data <= '0;
         hold_addr <= '0;
         hold_write <= 1'b0;
      end else begin
         case (phase)
            ST_IDLE: begin
               if (issue) begin
                  last_src <= winner;
                  if (split) begin
                     phase <= ST_LOW;
                     hold_addr <= win_addr;
                     hold_data <= win_wdata;
                     hold_write <= win_write;
                  end
               end else begin
                  last_src <= SRC_NONE;
               end
            end
            ST_LOW: begin
               phase <= ST_HIGH;
               hold_data[HALF_W-1:0] <= periph_rdata[HALF_W-1:0];
            end
            ST_HIGH: begin
               phase <= ST_IDLE;
            end
            default: begin
               phase <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Peripheral bus drive
   // ==========================================
   // Frame decode and 16-bit address
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         periph_sel_wide <= 1'b0;
         periph_sel_narrow <= 1'b0;
         periph_write <= 1'b0;
         periph_wide <= 1'b0;
         periph_addr <= '0;
         periph_wdata <= '0;
      end else if (phase == ST_LOW) begin
         periph_sel_narrow <= 1'b1;
         periph_write <= hold_write;
         periph_wide <= 1'b0;
         periph_addr <= hold_addr[PERIPH_AW-1:0] + 16'h0001;
         periph_wdata <= {{HALF_W{1'b0}}, hold_data[DW-1:HALF_W]};
      end else begin
         periph_sel_wide <= issue && win_frame == FRAME_WIDE;
         periph_sel_narrow <= issue && win_frame == FRAME_NARROW;
         periph_write <= issue && win_write;
         periph_wide <= issue && win_wide && !split;
         periph_addr <= win_addr[PERIPH_AW-1:0];
         periph_wdata <= split ? {{HALF_W{1'b0}}, win_wdata[HALF_W-1:0]} : win_wdata;
      end
   end

   // ==========================================
   // Completion
   // ==========================================
   // Unsplit transfer completes in the issue cycle
   logic finish;
   source_t done_src;
   assign finish = (issue && !split) || phase == ST_HIGH;
   assign done_src = phase == ST_HIGH ? last_src : winner;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         dwrite_done <= 1'b0;
         pwrite_done <= 1'b0;
         dread_done <= 1'b0;
         pread_done <= 1'b0;
         fetch_done <= 1'b0;
      end else begin
         dwrite_done <= finish && done_src == SRC_DWRITE;
         pwrite_done <= finish && done_src == SRC_PWRITE;
         dread_done <= finish && done_src == SRC_DREAD;
         pread_done <= finish && done_src == SRC_PREAD;
         fetch_done <= finish && done_src == SRC_FETCH;
      end
   end

   // Read data returns full 32 bits, or joined halves
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata <= '0;
      end else if (phase == ST_HIGH) begin
         rdata <= {periph_rdata[HALF_W-1:0], hold_data[HALF_W-1:0]};
      end else begin
         rdata <= periph_rdata;
      end
   end
endmodule
`default_nettype wire

/* test/bridge_checker_assertions.sv */
// Port-level assertions for the memory bus priority bridge
`timescale 1ns/1ps
`default_nettype none
module bridge_checker (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic dwrite_req,
   input wire logic [bus_bridge_pkg::DATA_AW-1:0] dwrite_addr,
   input wire logic [bus_bridge_pkg::DW-1:0] dwrite_data,
   input wire logic fetch_done,
   input wire logic pread_done,
   input wire logic pwrite_done,
   input wire logic dread_done,
   input wire logic dwrite_done,
   input wire logic [bus_bridge_pkg::DW-1:0] rdata,
   input wire logic [bus_bridge_pkg::DW-1:0] periph_rdata,
   input wire logic periph_sel_wide,
   input wire logic periph_sel_narrow,
   input wire logic periph_write,
   input wire logic periph_wide,
   input wire logic [bus_bridge_pkg::PERIPH_AW-1:0] periph_addr,
   input wire logic [bus_bridge_pkg::DW-1:0] periph_wdata,
   input wire logic protect_on
);
   import bus_bridge_pkg::*;
   wire logic [15:0] dw_off = dwrite_addr[15:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ====================
   // Properties
   sequence s_wr_protected;
      dwrite_done && protect_on && (periph_sel_wide || periph_sel_narrow);
   endsequence
   property p_reset; $rose(rst_b) |-> protect_on && !periph_sel_wide && !periph_sel_narrow;
   endproperty
   property p_one;
      $onehot0({fetch_done, pread_done, pwrite_done, dread_done, dwrite_done});
   endproperty
   property p_narrow; periph_sel_narrow |-> !periph_wide && !periph_sel_wide; endproperty
   property p_prio; dread_done && periph_sel_wide |-> !$past(dwrite_req); endproperty
   property p_write;
      dwrite_done && periph_sel_wide |->
         periph_write && periph_addr == $past(dw_off) && periph_wdata == $past(dwrite_data);
   endproperty
   property p_protect; s_wr_protected |=> !dread_done; endproperty
   property p_rdata; dread_done && periph_sel_wide |=> rdata == $past(periph_rdata); endproperty
   property p_cause; dwrite_done |-> $past(dwrite_req); endproperty
   a_reset: assert property (p_reset) else $error("bad reset state");
   a_one: assert property (p_one) else $error("two grants at once");
   a_narrow: assert property (p_narrow) else $error("wide narrow access");
   a_prio: assert property (p_prio) else $error("read beat write");
   a_write: assert property (p_write) else $error("bad write transfer");
   a_protect: assert property (p_protect) else $error("read not held");
   a_rdata: assert property (p_rdata) else $error("bad read data");
   a_cause: assert property (p_cause) else $error("grant without request");
endmodule
bind memory_bus_priority_bridge bridge_checker u_chk (.mclk, .rst_b, .dwrite_req,
   .dwrite_addr, .dwrite_data, .fetch_done, .pread_done, .pwrite_done, .dread_done,
   .dwrite_done, .rdata, .periph_rdata, .periph_sel_wide, .periph_sel_narrow,
   .periph_write, .periph_wide, .periph_addr, .periph_wdata, .protect_on);
`default_nettype wire

/* test/periph_model.sv */
// Peripheral register blocks answering reads on both frames
`timescale 1ns/1ps
`default_nettype none
module periph_model (
   input wire logic mclk,
   input wire logic periph_sel_wide,
   input wire logic periph_sel_narrow,
   input wire logic [bus_bridge_pkg::PERIPH_AW-1:0] periph_addr,
   output logic [bus_bridge_pkg::DW-1:0] periph_rdata
);
   import bus_bridge_pkg::*;
   logic [15:0] churn = 16'h0;
   always_ff @(posedge mclk) begin
      churn <= churn + 16'h1;
   end
   // Idle bus shows noise so stale data cannot pass as a match
   always_comb begin
      if (periph_sel_wide)
         periph_rdata = {periph_addr ^ 16'hC3C3, periph_addr ^ 16'h5A5A};
      else if (periph_sel_narrow)
         periph_rdata = {churn, periph_addr ^ 16'h5A5A};
      else
         periph_rdata = {~churn, churn};
   end
endmodule
`default_nettype wire

/* test/memory_bus_priority_bridge_test.sv */
// Self-checking bench for the memory bus priority bridge
`timescale 1ns/1ps
`default_nettype none
module memory_bus_priority_bridge_test;
   import bus_bridge_pkg::*;
   typedef struct packed {logic [2:0] k; logic rd; logic sp; logic [31:0] d;} note_t;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic protect_en = 1'b1;
   logic [4:0] req = 5'h00;
   logic [21:0] prog_addr = 22'h0;
   logic [31:0] prog_wdata = 32'h0, dwrite_data = 32'h0, dread_addr = 32'h0, dwrite_addr = 32'h0;
   logic prog_wide = 1'b1, dread_wide = 1'b1, dwrite_wide = 1'b0, rd_pend = 1'b0;
   wire logic [4:0] dn;
   wire logic [31:0] rdata, periph_rdata;
   wire logic [15:0] periph_addr;
   wire logic sel_w, sel_n, protect_on;
   logic [31:0] rd_exp;
   note_t q[$];
   note_t n;
   int n_fail = 0;
   int check_count = 0;
   memory_bus_priority_bridge DUT (.mclk(mclk), .rst_b(rst_b), .protect_en(protect_en),
      .fetch_req(req[4]), .pread_req(req[3]), .pwrite_req(req[1]), .prog_addr(prog_addr),
      .prog_wdata(prog_wdata), .prog_wide(prog_wide), .dread_req(req[2]),
      .dread_addr(dread_addr), .dread_wide(dread_wide), .dwrite_req(req[0]),
      .dwrite_addr(dwrite_addr), .dwrite_data(dwrite_data), .dwrite_wide(dwrite_wide),
      .fetch_done(dn[4]), .pread_done(dn[3]), .pwrite_done(dn[1]), .dread_done(dn[2]),
      .dwrite_done(dn[0]), .rdata(rdata), .periph_rdata(periph_rdata),
      .periph_sel_wide(sel_w), .periph_sel_narrow(sel_n), .periph_write(),
      .periph_wide(), .periph_addr(periph_addr), .periph_wdata(), .protect_on(protect_on));
   periph_model u_far (.mclk(mclk), .periph_sel_wide(sel_w), .periph_sel_narrow(sel_n),
      .periph_addr(periph_addr), .periph_rdata(periph_rdata));
   initial forever #12.5 mclk = ~mclk;
   // ====================
   // Checking
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk_src(input logic [4:0] s, input logic [4:0] e);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch grant exp %h got %h", e, s);
      end
   endtask
   task chk_dat(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch data exp %h got %h", e, s);
      end
   endtask
   always @(posedge mclk) begin
      #2;
      if (rd_pend)
         chk_dat(rdata, rd_exp);
      rd_pend = 1'b0;
      if (rst_b && dn !== 5'h00) begin
         n = (q.size() > 0) ? q.pop_front() : '0;
         chk_src(dn, 5'h01 << n.k);
         // Joined halves of a split read stand in the same cycle as the grant
         rd_pend = n.rd && !n.sp;
         rd_exp = n.d;
         if (n.rd && n.sp)
            chk_dat(rdata, n.d);
      end
   end
   // Notes go in priority order; a split narrow read joins high and low halves
   task automatic go(input logic [4:0] m);
      int k;
      note_t e;
      logic [15:0] a;
      a = dread_addr[15:0];
      for (k = 0; k < 5; k++) begin
         e.k = 3'(k);
         e.rd = (k == 2);
         e.sp = e.rd && dread_wide && (dread_addr[17:16] == FRAME_NARROW);
         e.d = (dread_addr[17:16] == FRAME_NARROW) ? {(a + 16'h1) ^ 16'h5A5A, a ^ 16'h5A5A}
            : {a ^ 16'hC3C3, a ^ 16'h5A5A};
         if (m[k])
            q.push_back(e);
      end
      req = m;
      for (k = 0; k < 40 && req != 5'h00; k++) begin
         @(posedge mclk);
         #1 req = req & ~dn;
      end
      chk_src(req, 5'h00);
      // Let an edge pass so a dropped request is never raised in the same step
      @(posedge mclk);
      #1;
   endtask
   logic [4:0] masks [6] = '{5'h0D, 5'h16, 5'h15, 5'h05, 5'h0A, 5'h04};
   initial begin
      int j;
      void'($urandom(32'hE490));
      repeat (5) @(posedge mclk);
      #1 rst_b = 1'b1;
      chk_dat({31'h0, protect_on}, 32'h1);
      for (j = 0; j < 24; j++) begin
         protect_en = (j < 12);
         prog_addr = {4'h0, FRAME_WIDE, 16'($urandom)};
         dread_addr = {14'h0, j[0] ? FRAME_NARROW : FRAME_WIDE, 16'($urandom)};
         dwrite_addr = {14'h0, j[1] ? FRAME_NARROW : FRAME_WIDE, 16'($urandom)};
         dwrite_data = $urandom;
         prog_wdata = $urandom;
         dwrite_wide = j[2];
         go(masks[j % 6]);
      end
      repeat (3) @(posedge mclk);
      chk_src(5'(q.size()), 5'h00);
      give_verdict();
   end
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end
endmodule
`default_nettype wire
